/* File: shared/uart_pkg.sv */
// Constants and types for the asynchronous serial transceiver
`default_nettype none
package uart_pkg;
  localparam int unsigned CLK_HZ = 50_000_000;

  // Register indexes; the byte address is four times the index
  localparam logic [7:0] IDX_NONE      = 8'h00;
  localparam logic [7:0] IDX_IRQ_FLAGS = 8'h0C;
  localparam logic [7:0] IDX_RX_CTRL   = 8'h18;
  localparam logic [7:0] IDX_TX_HOLD   = 8'h19;
  localparam logic [7:0] IDX_RX_DATA   = 8'h1A;
  localparam logic [7:0] IDX_IRQ_EN    = 8'h8C;
  localparam logic [7:0] IDX_TX_CTRL   = 8'h98;
  localparam logic [7:0] IDX_BAUD_DIV  = 8'h99;
  localparam logic [7:0] RST_TX_CTRL   = 8'h02;
  localparam logic [7:0] RST_RX_CTRL   = 8'h00;
  localparam logic [7:0] RST_OTHER     = 8'h00;

  // Field positions
  localparam int TXC_CLKSRC = 7;
  localparam int TXC_NINE   = 6;
  localparam int TXC_EN     = 5;
  localparam int TXC_SYNC   = 4;
  localparam int TXC_HSPEED = 2;
  localparam int TXC_EMPTY  = 1;
  localparam int TXC_NINTH  = 0;
  localparam int RXC_SERIAL_PORT_ENABLE   = 7;
  localparam int RXC_NINE   = 6;
  localparam int RXC_SINGLE = 5;
  localparam int RXC_CONT   = 4;
  localparam int RXC_ADDR   = 3;
  localparam int RXC_FRAMING_ERROR   = 2;
  localparam int RXC_OVERRUN_ERROR   = 1;
  localparam int RXC_NINTH  = 0;
  localparam int FLG_RX_RDY = 5;
  localparam int FLG_TX_EMP = 4;
  localparam int HTRANS_ACT = 1;

  // Sixteen samples per bit; majority taken from the middle three
  localparam logic [3:0] SUB_FIRST  = 4'h1;
  localparam logic [3:0] SUB_LAST   = 4'hF;
  localparam logic [3:0] SAMPLE_A   = 4'h7;
  localparam logic [3:0] SAMPLE_B   = 4'h8;
  localparam logic [3:0] SAMPLE_C   = 4'h9;
  localparam logic [1:0] PRE_LAST   = 2'h3;
  localparam logic [3:0] LAST_BIT8  = 4'h7;
  localparam logic [3:0] LAST_BIT9  = 4'h8;
  localparam int         FIFO_DEPTH = 2;
  localparam logic [1:0] FIFO_FULL  = 2'h2;

  typedef enum logic [1:0] {
    TX_IDLE  = 2'b00,
    TX_START = 2'b01,
    TX_DATA  = 2'b11,
    TX_STOP  = 2'b10
  } txState_t;

  typedef enum logic [1:0] {
    RX_IDLE  = 2'b00,
    RX_START = 2'b01,
    RX_DATA  = 2'b11,
    RX_STOP  = 2'b10
  } rxState_t;
endpackage
`default_nettype wire

/* File: logic/rx_word_mem.sv */
// Receive queue storage with registered read data
`default_nettype none
module rx_word_mem #(
  parameter int WIDTH = 10,
  parameter int DEPTH = 2,
  parameter int AW    = (DEPTH > 1) ? $clog2(DEPTH) : 1
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             wrEn,
  input  wire logic [AW-1:0]    wrAddr,
  input  wire logic [WIDTH-1:0] wrData,
  input  wire logic [AW-1:0]    rdAddr,
  output logic      [WIDTH-1:0] rdData
);
  logic [WIDTH-1:0] mem [DEPTH];

  always_ff @(posedge clk) begin
    if (wrEn) begin
      mem[wrAddr] <= wrData;
    end
  end

  // Write-through: a word pushed into an empty queue shows at once
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdData <= '0;
    end else if (wrEn && wrAddr == rdAddr) begin
      rdData <= wrData;
    end else begin
      rdData <= mem[rdAddr];
    end
  end
endmodule
`default_nettype wire

/* File: logic/async_serial_transceiver.sv */
// Asynchronous serial transmitter and receiver with an AHB-Lite register slave
// Contract
// - Shifter reloads from holding buffer only after previous stop bit completes.
// - Holding-to-shifter transfer takes one cycle, then sets buffer-empty flag bit 4.
// - Buffer-empty flag ignores its enable, software cannot clear it, buffer write clears.
// - Read-only shifter-empty status at transmit control bit 1, no interrupt.
// - Setting transmit enable sets buffer-empty flag; loading holding buffer clears it.
// - Transmit enable is bit 5; frame waits for loaded data and shift clock.
// - Holding buffer may be written before enable; sending starts once enabled.
// - Write with empty shifter moves straight in, freeing buffer for next byte.
// - Dropping transmit enable aborts frame, resets transmitter, releases transmit pin.
// - Transmit control bit 6 selects nine bits; bit 0 is the ninth bit.
// - Receive line sampled sixteen times per bit; shifter advances per bit.
// - Continuous receive enable at receive control bit 4 turns reception on.
// - After stop bit, word enters queue if room, ready flag bit 5 set.
// - Ready flag is read-only, cleared by hardware when queue read empty.
// - Receive queue holds two words; third may shift meanwhile; reads return both.
// - Queue full at third stop bit sets overrun bit 1, word discarded.
// - Overrun blocks queue loads; cleared only by dropping continuous receive enable or serial port enable.
// - Framing error bit 2 set when sampled stop bit is low.
// - Framing error and ninth bit queue with data; data read shows next word's.
// - Nine-bit receive captures the ninth bit into its status field.
// - Frame is start, eight or nine data bits LSB first, one stop.
// - Shift clock is 16 or 64 times bit rate, divisor plus one.
// - Each received bit is the majority of three samples.
// - Address detect in nine-bit mode keeps only words with ninth bit set.
//
// Added by the designer: the AHB-Lite slave port.
`default_nettype none
module async_serial_transceiver
  import uart_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  input  wire logic        rxPin,
  output logic             txPin,
  output logic             txPinOe_n
);
  typedef struct packed {
    logic        hreadyout;
    logic        hresp;
    logic [31:0] hrdata;
    logic        dpWrite;
    logic        rdPend;
    logic [7:0]  dpIdx;
    logic        clockSourceSel;
    logic        txNineBitSel;
    logic        txEnable;
    logic        syncModeSel;
    logic        highSpeedBaudSel;
    logic        txNinthBit;
    logic        serialPortEnable;
    logic        rxNineBitSel;
    logic        singleRxEnable;
    logic        continuousRxEnable;
    logic        addressDetectEnable;
    logic [7:0]  periphIrqEnables;
    logic [7:0]  baudDivisor;
    logic [7:0]  txHoldingBuffer;
    logic        holdFull;
    logic        txBufferEmptyFlag;
    logic        tsrFull;
    logic        txNine;
    txState_t    txState;
    logic [8:0]  txShiftReg;
    logic [3:0]  txBits;
    logic [3:0]  txSub;
    logic        txLine;
    logic        txOe_n;
    logic [7:0]  brgCnt;
    logic [1:0]  brgPre;
    rxState_t    rxState;
    logic [3:0]  rxSub;
    logic [3:0]  rxBits;
    logic [8:0]  rxShiftReg;
    logic [1:0]  rxSamp;
    logic        overrunError;
    logic        wrPtr;
    logic        rdPtr;
    logic [1:0]  count;
  } state_t;

  state_t     s;
  state_t     n;
  logic [9:0] headWord;
  logic [9:0] pushWord;
  logic       busTake;
  logic       holdWr;
  logic       pop;
  logic       push;
  logic       txLoad;
  logic       stopDone;
  logic       baudTick;
  logic       sampleTick;
  logic       brgRun;
  logic       rxOn;
  logic       bitVal;
  logic [7:0] wrByte;
  logic [7:0] rd;

  function automatic logic maj3(input logic a, input logic b, input logic c);
    return (a & b) | (a & c) | (b & c);
  endfunction

  function automatic logic [7:0] regIdx(input logic [31:0] a);
    // Anything outside the low kilobyte decodes to no register
    return (a[31:10] == 22'h0) ? a[9:2] : IDX_NONE;
  endfunction

  rx_word_mem #(
    .WIDTH (10),
    .DEPTH (FIFO_DEPTH)
  ) u_rx_mem (
    .clk    (clk),
    .rst_n  (rst_n),
    .wrEn   (push),
    .wrAddr (s.wrPtr),
    .wrData (pushWord),
    .rdAddr (n.rdPtr),
    .rdData (headWord)
  );

  always_comb begin
    n = s;
    wrByte = hwdata[7:0];
    rd = RST_OTHER;
    push = 1'b0;
    stopDone = 1'b0;
    pushWord = '0;
    bitVal = maj3(s.rxSamp[0], s.rxSamp[1], rxPin);

    // Bus: writes land in the data phase; reads take one wait state
    busTake = hsel && hready && htrans[HTRANS_ACT];
    n.hreadyout = !(busTake && !hwrite);
    n.rdPend = busTake && !hwrite;
    n.dpWrite = busTake && hwrite;
    if (busTake) begin
      n.dpIdx = regIdx(haddr);
    end
    n.hresp = 1'b0;
    holdWr = s.dpWrite && s.dpIdx == IDX_TX_HOLD;
    pop = s.rdPend && s.dpIdx == IDX_RX_DATA && s.count != 2'h0;

    if (s.rdPend) begin
      case (s.dpIdx)
        IDX_IRQ_FLAGS: begin
          rd[FLG_RX_RDY] = s.count != 2'h0;
          rd[FLG_TX_EMP] = s.txBufferEmptyFlag;
        end
        IDX_RX_CTRL: begin
          rd[RXC_SERIAL_PORT_ENABLE] = s.serialPortEnable;
          rd[RXC_NINE] = s.rxNineBitSel;
          rd[RXC_SINGLE] = s.singleRxEnable;
          rd[RXC_CONT] = s.continuousRxEnable;
          rd[RXC_ADDR] = s.addressDetectEnable;
          rd[RXC_FRAMING_ERROR] = headWord[9];
          rd[RXC_OVERRUN_ERROR] = s.overrunError;
          rd[RXC_NINTH] = headWord[8];
        end
        IDX_TX_HOLD: begin
          rd = s.txHoldingBuffer;
        end
        IDX_RX_DATA: begin
          rd = headWord[7:0];
        end
        IDX_IRQ_EN: begin
          rd = s.periphIrqEnables;
        end
        IDX_TX_CTRL: begin
          rd[TXC_CLKSRC] = s.clockSourceSel;
          rd[TXC_NINE] = s.txNineBitSel;
          rd[TXC_EN] = s.txEnable;
          rd[TXC_SYNC] = s.syncModeSel;
          rd[TXC_HSPEED] = s.highSpeedBaudSel;
          rd[TXC_EMPTY] = !s.tsrFull;
          rd[TXC_NINTH] = s.txNinthBit;
        end
        IDX_BAUD_DIV: begin
          rd = s.baudDivisor;
        end
        default: begin
          rd = RST_OTHER;
        end
      endcase
      n.hrdata = {24'h0, rd};
    end

    // Baud generator, held cleared while nothing uses it
    brgRun = s.serialPortEnable && (s.txEnable || s.continuousRxEnable);
    baudTick = brgRun && s.brgCnt == 8'h00;
    sampleTick = baudTick && (s.highSpeedBaudSel || s.brgPre == PRE_LAST);
    if (!brgRun) begin
      n.brgCnt = 8'h00;
      n.brgPre = 2'h0;
    end else if (baudTick) begin
      n.brgCnt = s.baudDivisor;
      n.brgPre = s.brgPre + 2'h1;
    end else begin
      n.brgCnt = s.brgCnt - 8'h01;
    end

    // Transmit: the shifter takes a word only once fully drained
    txLoad = s.txEnable && s.holdFull && !s.tsrFull;
    if (txLoad) begin
      n.tsrFull = 1'b1;
      n.txShiftReg = {s.txNinthBit, s.txHoldingBuffer};
      n.txNine = s.txNineBitSel;
      n.holdFull = 1'b0;
      n.txBufferEmptyFlag = 1'b1;
    end
    if (sampleTick) begin
      case (s.txState)
        TX_IDLE: begin
          if (s.tsrFull) begin
            n.txState = TX_START;
            n.txSub = 4'h0; // Start bit gets all sixteen ticks, like the data bits
          end
        end
        TX_START: begin
          n.txSub = s.txSub + 4'h1;
          if (s.txSub == SUB_LAST) begin
            n.txState = TX_DATA;
            n.txBits = 4'h0;
          end
        end
        TX_DATA: begin
          n.txSub = s.txSub + 4'h1;
          if (s.txSub == SUB_LAST) begin
            n.txShiftReg = {1'b0, s.txShiftReg[8:1]};
            n.txBits = s.txBits + 4'h1;
            if (s.txBits == (s.txNine ? LAST_BIT9 : LAST_BIT8)) begin
              n.txState = TX_STOP;
            end
          end
        end
        TX_STOP: begin
          n.txSub = s.txSub + 4'h1;
          if (s.txSub == SUB_LAST) begin
            n.txState = TX_IDLE;
            n.tsrFull = 1'b0;
          end
        end
        default: begin
          n.txState = TX_IDLE;
        end
      endcase
    end
    if (!s.txEnable) begin
      n.txState = TX_IDLE;
      n.tsrFull = 1'b0;
      n.txSub = 4'h0;
    end

    // Receive
    rxOn = s.serialPortEnable && s.continuousRxEnable;
    if (!rxOn) begin
      n.rxState = RX_IDLE;
      n.overrunError = 1'b0;
      n.rxSub = 4'h0;
    end else if (sampleTick) begin
      n.rxSub = s.rxSub + 4'h1;
      if (s.rxSub == SAMPLE_A) begin
        n.rxSamp[0] = rxPin;
      end
      if (s.rxSub == SAMPLE_B) begin
        n.rxSamp[1] = rxPin;
      end
      case (s.rxState)
        RX_IDLE: begin
          n.rxSub = SUB_FIRST;
          if (!rxPin) begin
            n.rxState = RX_START;
          end
        end
        RX_START: begin
          if (s.rxSub == SAMPLE_C && bitVal) begin
            n.rxState = RX_IDLE; // A glitch shorter than half a bit is no start
          end else if (s.rxSub == SUB_LAST) begin
            n.rxState = RX_DATA;
            n.rxBits = 4'h0;
          end
        end
        RX_DATA: begin
          if (s.rxSub == SAMPLE_C) begin
            n.rxShiftReg = {bitVal, s.rxShiftReg[8:1]};
          end
          if (s.rxSub == SUB_LAST) begin
            n.rxBits = s.rxBits + 4'h1;
            if (s.rxBits == (s.rxNineBitSel ? LAST_BIT9 : LAST_BIT8)) begin
              n.rxState = RX_STOP;
            end
          end
        end
        RX_STOP: begin
          if (s.rxSub == SAMPLE_C) begin
            stopDone = 1'b1;
            n.rxState = RX_IDLE;
          end
        end
        default: begin
          n.rxState = RX_IDLE;
        end
      endcase
    end
    // Queue word: framing error, ninth bit, data
    pushWord[9] = !bitVal;
    pushWord[8] = s.rxNineBitSel && s.rxShiftReg[8];
    pushWord[7:0] = s.rxNineBitSel ? s.rxShiftReg[7:0] : s.rxShiftReg[8:1];
    if (stopDone && !s.overrunError) begin
      if (s.count == FIFO_FULL) begin
        n.overrunError = 1'b1;
      end else if (!(s.rxNineBitSel && s.addressDetectEnable && !pushWord[8])) begin
        push = 1'b1;
      end
    end
    if (push) begin
      n.wrPtr = !s.wrPtr;
    end
    if (pop) begin
      n.rdPtr = !s.rdPtr;
    end
    n.count = s.count + {1'b0, push} - {1'b0, pop};

    // Register writes; a buffer load here outranks the transfer above
    if (s.dpWrite) begin
      case (s.dpIdx)
        IDX_RX_CTRL: begin
          n.serialPortEnable = wrByte[RXC_SERIAL_PORT_ENABLE];
          n.rxNineBitSel = wrByte[RXC_NINE];
          n.singleRxEnable = wrByte[RXC_SINGLE];
          n.continuousRxEnable = wrByte[RXC_CONT];
          n.addressDetectEnable = wrByte[RXC_ADDR];
        end
        IDX_TX_HOLD: begin
          n.txHoldingBuffer = wrByte;
          n.holdFull = 1'b1;
          n.txBufferEmptyFlag = 1'b0;
        end
        IDX_IRQ_EN: begin
          n.periphIrqEnables = wrByte;
        end
        IDX_TX_CTRL: begin
          n.clockSourceSel = wrByte[TXC_CLKSRC];
          n.txNineBitSel = wrByte[TXC_NINE];
          n.txEnable = wrByte[TXC_EN];
          n.syncModeSel = wrByte[TXC_SYNC];
          n.highSpeedBaudSel = wrByte[TXC_HSPEED];
          n.txNinthBit = wrByte[TXC_NINTH];
          if (wrByte[TXC_EN] && !s.txEnable) begin
            n.txBufferEmptyFlag = 1'b1;
          end
        end
        IDX_BAUD_DIV: begin
          n.baudDivisor = wrByte;
          n.brgCnt = 8'h00; // New rate takes effect without waiting a period
          n.brgPre = 2'h0;
        end
        default: begin
          n.dpWrite = n.dpWrite;
        end
      endcase
    end

    // Pin drive follows the next state so it leaves a flop aligned with it
    case (n.txState)
      TX_START: n.txLine = 1'b0;
      TX_DATA:  n.txLine = n.txShiftReg[0];
      default:  n.txLine = 1'b1;
    endcase
    n.txOe_n = !(n.serialPortEnable && n.txEnable);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
      s.hreadyout <= 1'b1;
      s.txLine <= 1'b1;
      s.txOe_n <= 1'b1;
    end else begin
      s <= n;
    end
  end

  assign hreadyout = s.hreadyout;
  assign hrdata = s.hrdata;
  assign hresp = s.hresp;
  assign txPin = s.txLine;
  assign txPinOe_n = s.txOe_n;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  AST_LOAD_AFTER_STOP: assert property (
    $rose(s.tsrFull) |-> $past(s.txState) == TX_IDLE && $past(s.holdFull) && $past(s.txEnable))
    else $error("shifter loaded while busy or without data");
  AST_FLAG_ON_TRANSFER: assert property (
    $rose(s.tsrFull) && !$past(holdWr) |-> s.txBufferEmptyFlag && !s.holdFull)
    else $error("transfer did not set buffer-empty flag");
  AST_FLAG_CLEAR: assert property (
    $fell(s.txBufferEmptyFlag) |-> $past(holdWr))
    else $error("buffer-empty flag cleared without a buffer write");
  AST_SHIFTER_EMPTY: assert property (
    s.txState != TX_IDLE |-> s.tsrFull)
    else $error("frame running with empty shifter");
  AST_ENABLE_SETS_FLAG: assert property (
    $rose(s.txEnable) |-> s.txBufferEmptyFlag)
    else $error("enable did not set buffer-empty flag");
  AST_ABORT: assert property (
    $fell(s.txEnable) |-> s.txOe_n ##1 (!s.tsrFull && s.txState == TX_IDLE))
    else $error("disable did not abort and release pin");
  AST_IDLE_HIGH: assert property (
    !s.txOe_n && s.txState inside {TX_IDLE, TX_STOP} |-> s.txLine)
    else $error("idle line not high");
  AST_FIFO_DEPTH: assert property (
    push |=> s.count != 2'h0 && s.count <= FIFO_FULL)
    else $error("queue count out of range after push");
  AST_OVERRUN_SET: assert property (
    stopDone && s.count == FIFO_FULL && !pop |=> s.overrunError && s.count == FIFO_FULL)
    else $error("full queue did not flag overrun");
  AST_OVERRUN_INHIBIT: assert property (
    s.overrunError |=> s.count <= $past(s.count))
    else $error("queue loaded during overrun");
  AST_READY_CLEAR: assert property (
    (s.count != 2'h0) ##1 (s.count == 2'h0) |-> $past(pop))
    else $error("ready flag cleared without a data read");
endmodule
`default_nettype wire

/* File: verification/serial_peer.sv */
// Remote serial peer: frames words onto the receive line, decodes the transmit line
`default_nettype none
module serial_peer (
  input  wire logic clk,
  input  wire logic txPin,
  input  wire logic txPinOe_n,
  output logic      rxPin
);
  timeunit 1ns;
  timeprecision 1ps;
  // Bit length in clocks; the bench sets it to match the baud setting
  int         bitClks = 16;
  logic       nineBits;
  logic [9:0] gotQ [$];
  logic [9:0] w;

  initial begin
    rxPin = 1'b1;
    nineBits = 1'b0;
  end

  // One idle bit after each nine-bit frame and two after each eight-bit frame so a low stop cannot fake the next start
  task automatic sendFrame(input logic [8:0] d, input logic stopLvl);
    logic [10:0] f;
    f = nineBits ? {stopLvl, d, 1'b0} : {1'b1, stopLvl, d[7:0], 1'b0};
    for (int i = 0; i < 11; i++) begin
      rxPin <= f[i];
      repeat (bitClks) @(posedge clk);
    end
    rxPin <= 1'b1;
    repeat (bitClks) @(posedge clk);
  endtask

  // Mid-bit sampling; stop level kept in bit 9
  always begin
    @(negedge txPin iff txPinOe_n === 1'b0);
    w = '0;
    repeat (bitClks / 2) @(posedge clk);
    for (int i = 0; i < (nineBits ? 9 : 8); i++) begin
      repeat (bitClks) @(posedge clk);
      w[i] = txPin;
    end
    repeat (bitClks) @(posedge clk);
    w[9] = txPin;
    gotQ.push_back(w);
  end
endmodule
`default_nettype wire

/* File: verification/tb_top.sv */
// Self-checking bench for the asynchronous serial transceiver
`default_nettype none
module tb_top
  import uart_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, rst_n, hsel, hwrite, hready, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0]  htrans;
  logic        rxPin, txPin, txPinOe_n;
  int          nMismatch = 0;
  int          numChecks = 0;
  logic [7:0]  b0, b1, b2;
  logic [7:0]  resetIdx [7] = '{IDX_IRQ_FLAGS, IDX_RX_CTRL, IDX_TX_HOLD, IDX_RX_DATA,
                                IDX_IRQ_EN, IDX_BAUD_DIV, 8'h01};
  assign hready = hreadyout;

  async_serial_transceiver DUT (.clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .rxPin(rxPin),
    .txPin(txPin), .txPinOe_n(txPinOe_n));
  serial_peer peer (.clk(clk), .txPin(txPin), .txPinOe_n(txPinOe_n), .rxPin(rxPin));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    numChecks++;
    if (got !== exp) begin
      nMismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic done(input string s);
    $display("test %s finished", s);
  endtask

  task automatic finishTest();
    $display("checks %0d mismatches %0d", numChecks, nMismatch);
    if (nMismatch == 0 && numChecks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Single word transfer; waits on the slave, never on a fixed count
  task automatic bus(input logic we, input logic [7:0] idx, input logic [7:0] wd,
                     output logic [7:0] d);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    hwrite <= we;
    haddr  <= {22'h0, idx, 2'h0};
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h0, wd};
    do @(posedge clk); while (hreadyout !== 1'b1);
    d = hrdata[7:0];
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] v);
    logic [7:0] d;
    bus(1'b1, idx, v, d);
  endtask

  task automatic rdChk(input logic [7:0] idx, input logic [7:0] m, input logic [7:0] e);
    logic [7:0] d;
    bus(1'b0, idx, 8'h00, d);
    chk({24'h0, d & m}, {24'h0, e});
    chk({31'h0, hresp}, 32'h0);
  endtask

  // Missing frame compares against the inverse so it cannot pass
  task automatic popChk(input logic [9:0] e);
    logic [9:0] g;
    g = ~e;
    for (int k = 0; k < 3000 && peer.gotQ.size() == 0; k++) @(posedge clk);
    if (peer.gotQ.size() > 0) g = peer.gotQ.pop_front();
    chk({22'h0, g}, {22'h0, e});
  endtask

  initial begin
    #600us;
    nMismatch++;
    finishTest();
  end

  initial begin
    rst_n = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
    void'($urandom(32'h658E0782));
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rdChk(IDX_TX_CTRL, 8'hFF, 8'h02);
    foreach (resetIdx[i]) rdChk(resetIdx[i], 8'hFF, 8'h00);
    wr(IDX_IRQ_FLAGS, 8'hFF);
    wr(IDX_TX_CTRL, 8'h00);
    rdChk(IDX_TX_CTRL, 8'hFF, 8'h02);
    rdChk(IDX_IRQ_FLAGS, 8'hFF, 8'h00);
    b0 = 8'($urandom);
    wr(IDX_IRQ_EN, b0);
    rdChk(IDX_IRQ_EN, 8'hFF, b0);
    done("reset");
    wr(IDX_BAUD_DIV, 8'h00);
    wr(IDX_RX_CTRL, 8'h90);
    b0 = 8'($urandom);
    wr(IDX_TX_HOLD, b0);
    wr(IDX_TX_CTRL, 8'h24);
    rdChk(IDX_IRQ_FLAGS, 8'h10, 8'h10);
    rdChk(IDX_TX_CTRL, 8'h02, 8'h00);
    popChk({2'b10, b0});
    done("preload");
    // Shifter must be idle, or the second write would overwrite the first
    do bus(1'b0, IDX_TX_CTRL, 8'h00, b2); while (!b2[TXC_EMPTY]);
    b1 = 8'($urandom);
    b2 = 8'($urandom);
    wr(IDX_TX_HOLD, b1);
    rdChk(IDX_IRQ_FLAGS, 8'h10, 8'h10);
    wr(IDX_TX_HOLD, b2);
    rdChk(IDX_IRQ_FLAGS, 8'h10, 8'h00);
    popChk({2'b10, b1});
    popChk({2'b10, b2});
    repeat (16) @(posedge clk);
    rdChk(IDX_TX_CTRL, 8'h02, 8'h02);
    wr(IDX_IRQ_FLAGS, 8'h00);
    rdChk(IDX_IRQ_FLAGS, 8'h10, 8'h10);
    done("back to back");
    peer.nineBits = 1'b1;
    for (int i = 0; i < 2; i++) begin
      b0 = 8'($urandom);
      wr(IDX_TX_CTRL, 8'h64 | 8'(i));
      wr(IDX_TX_HOLD, b0);
      popChk({1'b1, i[0], b0});
    end
    peer.nineBits = 1'b0;
    wr(IDX_TX_CTRL, 8'h24);
    repeat (20) @(posedge clk);
    chk({30'h0, txPinOe_n, txPin}, 32'h1);
    wr(IDX_TX_HOLD, 8'($urandom));
    repeat (40) @(posedge clk);
    wr(IDX_TX_CTRL, 8'h04);
    repeat (2) @(posedge clk);
    chk({31'h0, txPinOe_n}, 32'h1);
    rdChk(IDX_TX_CTRL, 8'h02, 8'h02);
    repeat (200) @(posedge clk);
    peer.gotQ.delete();
    done("nine bit and abort");
    b0 = 8'($urandom);
    b1 = 8'($urandom);
    b2 = 8'($urandom);
    peer.sendFrame({1'b0, b0}, 1'b1);
    rdChk(IDX_IRQ_FLAGS, 8'h20, 8'h20);
    peer.sendFrame({1'b0, b1}, 1'b1);
    peer.sendFrame({1'b0, b2}, 1'b1);
    rdChk(IDX_RX_CTRL, 8'h02, 8'h02);
    rdChk(IDX_RX_DATA, 8'hFF, b0);
    rdChk(IDX_IRQ_FLAGS, 8'h20, 8'h20);
    rdChk(IDX_RX_DATA, 8'hFF, b1);
    rdChk(IDX_IRQ_FLAGS, 8'h20, 8'h00);
    peer.sendFrame({1'b0, b2}, 1'b1);
    rdChk(IDX_IRQ_FLAGS, 8'h20, 8'h00);
    wr(IDX_RX_CTRL, 8'h80);
    wr(IDX_RX_CTRL, 8'h90);
    rdChk(IDX_RX_CTRL, 8'h02, 8'h00);
    done("overrun");
    peer.sendFrame({1'b0, b0}, 1'b0);
    peer.sendFrame({1'b0, b1}, 1'b1);
    rdChk(IDX_RX_CTRL, 8'h04, 8'h04);
    rdChk(IDX_RX_DATA, 8'hFF, b0);
    rdChk(IDX_RX_CTRL, 8'h04, 8'h00);
    rdChk(IDX_RX_DATA, 8'hFF, b1);
    done("framing");
    peer.nineBits = 1'b1;
    wr(IDX_RX_CTRL, 8'hD0);
    peer.sendFrame({1'b1, b2}, 1'b1);
    rdChk(IDX_RX_CTRL, 8'h01, 8'h01);
    rdChk(IDX_RX_DATA, 8'hFF, b2);
    wr(IDX_RX_CTRL, 8'hD8);
    peer.sendFrame({1'b0, b0}, 1'b1);
    rdChk(IDX_IRQ_FLAGS, 8'h20, 8'h00);
    peer.sendFrame({1'b1, b1}, 1'b1);
    rdChk(IDX_RX_DATA, 8'hFF, b1);
    done("nine bit receive");
    // Low speed with divisor one: 64 * 2 clocks per bit
    peer.nineBits = 1'b0;
    peer.bitClks = 128;
    wr(IDX_BAUD_DIV, 8'h01);
    wr(IDX_TX_CTRL, 8'h20);
    wr(IDX_TX_HOLD, b0);
    popChk({2'b10, b0});
    done("low speed baud");
    finishTest();
  end
endmodule
`default_nettype wire
